// ==== sfc_pkg.sv ====
/*
 * Shared constants and carrier types for the shared byte queue with CRC engine.
 * Assumes a single 25 MHz clock domain; no register bus, all controls are plain ports.
 */
package sfc_pkg;

	localparam int QUEUE_DEPTH = 64;
	localparam int PTR_W = 6;
	localparam int COUNT_W = 7;
	localparam int THRESH_W = 6;
	localparam int CRC_W = 16;

	localparam logic [COUNT_W-1:0] COUNT_FULL = 7'h40;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 7'h00;
	localparam logic [PTR_W-1:0] PTR_ZERO = 6'h00;
	localparam logic [PTR_W-1:0] PTR_STEP = 6'h01;
	localparam logic [COUNT_W-1:0] COUNT_STEP = 7'h01;

	localparam logic [1:0] SEED_SEL_ZERO = 2'h0;
	localparam logic [1:0] SEED_SEL_6363 = 2'h1;
	localparam logic [1:0] SEED_SEL_A671 = 2'h2;
	localparam logic [CRC_W-1:0] CRC_SEED_0 = 16'h0000;
	localparam logic [CRC_W-1:0] CRC_SEED_1 = 16'h6363;
	localparam logic [CRC_W-1:0] CRC_SEED_2 = 16'ha671;
	localparam logic [CRC_W-1:0] CRC_SEED_3 = 16'hffff;
	localparam logic [CRC_W-1:0] CRC_POLY_REFL = 16'h8408;
	localparam logic [CRC_W-1:0] CRC_POLY_NORM = 16'h1021;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_ZERO = 3'h0;

	typedef enum logic [1:0]
	{
		SFC_CRC_IDLE = 2'b00,
		SFC_CRC_FETCH = 2'b01,
		SFC_CRC_SHIFT = 2'b10
	} sfc_crc_state_e;

	typedef struct packed
	{
		logic [1:0] seed_select;
		logic bit_order;
	} sfc_crc_cfg_s;

	typedef struct packed
	{
		logic near_full_flag;
		logic near_empty_flag;
		logic overflow_error;
		logic [COUNT_W-1:0] queue_count;
	} sfc_status_s;

endpackage : sfc_pkg

// ==== sfc_queue_crc.sv ====
/*
 * Shared 64-byte queue between the host port and internal command logic, with a
 * 16-bit CRC engine that drains the queue. Assumes host and command logic share clk_in.
 */
`timescale 1ns/1ps
// Overview of operation
// - One queue of 64 byte-wide entries shared by host and command logic.
// - A host write stores the byte at the write pointer, then advances it.
// - A host read returns the byte at the read pointer, then advances it.
// - A seven-bit count of stored bytes is readable by the host.
// - Running commands may read or write the same queue.
// - Clearing resets both pointers, zeroes the count and clears overflow unless a write meets a full queue in the same cycle.
// - Overflow stays set until a clear; nothing else clears it.
// - Near-full is set when free space is at most the threshold.
// - Near-empty is set when the count is at most the threshold.
// - Enabled near-empty rising edge activates the interrupt output.
// - Enabled near-full rising edge activates the interrupt output.
// - Enabled events set a pending bit; interrupt pin drives only if activated.
// - Two-bit select picks CRC seed 0000h, 6363h, a671h or ffffh.
// - CRC uses polynomial x^16 + x^12 + x^5 + 1.
// - CRC result reads as separate upper and lower bytes.
// - With bit order set, CRC takes each byte most significant bit first.
// - When the queue is drained the CRC ready and done request flags set.
module sfc_queue_crc #(
	parameter int DEPTH = sfc_pkg::QUEUE_DEPTH
)
(
	// Clock, reset and enable.
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	// Host data port.
	input wire logic host_wr_in,
	input wire logic [7:0] host_wdata_in,
	input wire logic host_rd_in,
	output logic [7:0] host_rdata_out,
	// Internal command logic port.
	input wire logic cmd_wr_in,
	input wire logic [7:0] cmd_wdata_in,
	input wire logic cmd_rd_in,
	output logic [7:0] cmd_rdata_out,
	// Control and configuration.
	input wire logic queue_clear_in,
	input wire logic [sfc_pkg::THRESH_W-1:0] threshold_in,
	input wire logic near_empty_irq_enable_in,
	input wire logic near_full_irq_enable_in,
	input wire logic irq_activate_in,
	input wire logic pending_clear_in,
	input wire sfc_pkg::sfc_crc_cfg_s crc_cfg_in,
	input wire logic crc_start_in,
	input wire logic crc_done_clear_in,
	// Status.
	output sfc_pkg::sfc_status_s status_out,
	output logic pending_out,
	output logic irq_out,
	output logic [7:0] crc_output_hi_out,
	output logic [7:0] crc_output_lo_out,
	output logic crc_done_flag_out,
	output logic crc_done_request_out
);

	logic [7:0] mem_r [DEPTH];
	logic [sfc_pkg::PTR_W-1:0] wptr_r, wptr_nxt;
	logic [sfc_pkg::PTR_W-1:0] rptr_r, rptr_nxt;
	logic [sfc_pkg::COUNT_W-1:0] count_r, count_nxt;
	logic ovf_r, ovf_nxt;
	logic nf_r, nf_nxt;
	logic ne_r, ne_nxt;
	logic pend_r, pend_nxt;
	logic irq_r, irq_nxt;
	logic [7:0] hrd_r, hrd_nxt;
	logic [7:0] crd_r, crd_nxt;
	logic do_wr, do_rd, crc_rd;
	logic [7:0] wr_byte;
	logic [sfc_pkg::COUNT_W-1:0] free_cnt;

	sfc_pkg::sfc_crc_state_e cst_r, cst_nxt;
	logic [sfc_pkg::CRC_W-1:0] crc_r, crc_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic done_r, done_nxt;
	logic req_r, req_nxt;
	logic msb_r, msb_nxt;
	logic fb;

	// Queue pointer, count and flag logic.
	always_comb
	begin
		wptr_nxt = wptr_r;
		rptr_nxt = rptr_r;
		count_nxt = count_r;
		ovf_nxt = ovf_r;
		hrd_nxt = hrd_r;
		crd_nxt = crd_r;
		pend_nxt = pend_r;
		irq_nxt = irq_r;
		wr_byte = host_wr_in ? host_wdata_in : cmd_wdata_in;
		crc_rd = (cst_r == sfc_pkg::SFC_CRC_FETCH) && (count_r != sfc_pkg::COUNT_ZERO);
		do_wr = (host_wr_in || cmd_wr_in) && (count_r != sfc_pkg::COUNT_FULL);
		do_rd = (host_rd_in || cmd_rd_in || crc_rd) &&
			(count_r != sfc_pkg::COUNT_ZERO);
		if (host_rd_in)
		begin
			hrd_nxt = mem_r[rptr_r];
		end
		if (cmd_rd_in)
		begin
			crd_nxt = mem_r[rptr_r];
		end
		if (do_wr)
		begin
			wptr_nxt = wptr_r + sfc_pkg::PTR_STEP;
		end
		if (do_rd)
		begin
			rptr_nxt = rptr_r + sfc_pkg::PTR_STEP;
		end
		if (do_wr && !do_rd)
		begin
			count_nxt = count_r + sfc_pkg::COUNT_STEP;
		end
		else if (do_rd && !do_wr)
		begin
			count_nxt = count_r - sfc_pkg::COUNT_STEP;
		end
		if (queue_clear_in)
		begin
			wptr_nxt = sfc_pkg::PTR_ZERO;
			rptr_nxt = sfc_pkg::PTR_ZERO;
			count_nxt = sfc_pkg::COUNT_ZERO;
			ovf_nxt = 1'b0;
		end
		if ((host_wr_in || cmd_wr_in) && (count_r == sfc_pkg::COUNT_FULL))
		begin
			ovf_nxt = 1'b1;
		end
		free_cnt = sfc_pkg::COUNT_FULL - count_nxt;
		nf_nxt = free_cnt <= {1'b0, threshold_in};
		ne_nxt = count_nxt <= {1'b0, threshold_in};
		if (pending_clear_in)
		begin
			pend_nxt = 1'b0;
		end
		if ((near_empty_irq_enable_in && ne_nxt && !ne_r) ||
			(near_full_irq_enable_in && nf_nxt && !nf_r))
		begin
			pend_nxt = 1'b1;
		end
		irq_nxt = pend_nxt && irq_activate_in;
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			wptr_r <= sfc_pkg::PTR_ZERO;
			rptr_r <= sfc_pkg::PTR_ZERO;
			count_r <= sfc_pkg::COUNT_ZERO;
			ovf_r <= 1'b0;
			nf_r <= 1'b0;
			ne_r <= 1'b1;
			pend_r <= 1'b0;
			irq_r <= 1'b0;
			hrd_r <= 8'h00;
			crd_r <= 8'h00;
		end
		else if (clk_en_in)
		begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			count_r <= count_nxt;
			ovf_r <= ovf_nxt;
			nf_r <= nf_nxt;
			ne_r <= ne_nxt;
			pend_r <= pend_nxt;
			irq_r <= irq_nxt;
			hrd_r <= hrd_nxt;
			crd_r <= crd_nxt;
		end
	end

	// Storage array; written at the write pointer only when not full.
	always_ff @(posedge clk_in)
	begin
		if (clk_en_in && do_wr && !queue_clear_in)
		begin
			mem_r[wptr_r] <= wr_byte;
		end
	end

	// CRC engine: one bit per cycle, draining the queue until empty.
	always_comb
	begin
		cst_nxt = cst_r;
		crc_nxt = crc_r;
		sh_nxt = sh_r;
		bit_nxt = bit_r;
		done_nxt = done_r;
		req_nxt = req_r;
		msb_nxt = msb_r;
		fb = 1'b0;
		if (crc_done_clear_in)
		begin
			req_nxt = 1'b0;
		end
		case (cst_r)
			sfc_pkg::SFC_CRC_IDLE:
			begin
				if (crc_start_in)
				begin
					msb_nxt = crc_cfg_in.bit_order;
					done_nxt = 1'b0;
					cst_nxt = sfc_pkg::SFC_CRC_FETCH;
					case (crc_cfg_in.seed_select)
						sfc_pkg::SEED_SEL_ZERO: crc_nxt = sfc_pkg::CRC_SEED_0;
						sfc_pkg::SEED_SEL_6363: crc_nxt = sfc_pkg::CRC_SEED_1;
						sfc_pkg::SEED_SEL_A671: crc_nxt = sfc_pkg::CRC_SEED_2;
						default: crc_nxt = sfc_pkg::CRC_SEED_3;
					endcase
				end
			end
			sfc_pkg::SFC_CRC_FETCH:
			begin
				if (queue_clear_in || count_r == sfc_pkg::COUNT_ZERO)
				begin
					done_nxt = 1'b1;
					req_nxt = 1'b1;
					cst_nxt = sfc_pkg::SFC_CRC_IDLE;
				end
				else
				begin
					sh_nxt = mem_r[rptr_r];
					bit_nxt = sfc_pkg::BIT_ZERO;
					cst_nxt = sfc_pkg::SFC_CRC_SHIFT;
				end
			end
			sfc_pkg::SFC_CRC_SHIFT:
			begin
				if (msb_r)
				begin
					fb = crc_r[15] ^ sh_r[7];
					crc_nxt = {crc_r[14:0], 1'b0} ^ (fb ? sfc_pkg::CRC_POLY_NORM : '0);
					sh_nxt = {sh_r[6:0], 1'b0};
				end
				else
				begin
					fb = crc_r[0] ^ sh_r[0];
					crc_nxt = {1'b0, crc_r[15:1]} ^ (fb ? sfc_pkg::CRC_POLY_REFL : '0);
					sh_nxt = {1'b0, sh_r[7:1]};
				end
				bit_nxt = bit_r + 3'h1;
				if (bit_r == sfc_pkg::BIT_LAST)
				begin
					cst_nxt = sfc_pkg::SFC_CRC_FETCH;
				end
			end
			default:
			begin
				cst_nxt = sfc_pkg::SFC_CRC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cst_r <= sfc_pkg::SFC_CRC_IDLE;
			crc_r <= sfc_pkg::CRC_SEED_0;
			sh_r <= 8'h00;
			bit_r <= sfc_pkg::BIT_ZERO;
			done_r <= 1'b0;
			req_r <= 1'b0;
			msb_r <= 1'b0;
		end
		else if (clk_en_in)
		begin
			cst_r <= cst_nxt;
			crc_r <= crc_nxt;
			sh_r <= sh_nxt;
			bit_r <= bit_nxt;
			done_r <= done_nxt;
			req_r <= req_nxt;
			msb_r <= msb_nxt;
		end
	end

	assign host_rdata_out = hrd_r;
	assign cmd_rdata_out = crd_r;
	assign status_out = '{near_full_flag: nf_r, near_empty_flag: ne_r,
		overflow_error: ovf_r, queue_count: count_r};
	assign pending_out = pend_r;
	assign irq_out = irq_r;
	assign crc_output_hi_out = crc_r[15:8];
	assign crc_output_lo_out = crc_r[7:0];
	assign crc_done_flag_out = done_r;
	assign crc_done_request_out = req_r;

endmodule : sfc_queue_crc

// ==== sfc_queue_crc_assertions.sv ====
/* Concurrent checks on the ports of the shared queue with CRC engine.
   Assumes one clock; frozen cycles and command-port traffic skip the step checks. */
`timescale 1ns/1ps
module sfc_queue_crc_assertions #(
	parameter int DEPTH = 64
)
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic clk_en_in,
	// Requests and controls.
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	input wire logic cmd_wr_in,
	input wire logic cmd_rd_in,
	input wire logic queue_clear_in,
	input wire logic [5:0] threshold_in,
	input wire logic near_empty_irq_enable_in,
	input wire logic irq_activate_in,
	// Status.
	input wire sfc_pkg::sfc_status_s status_out,
	input wire logic pending_out,
	input wire logic irq_out,
	input wire logic crc_done_flag_out,
	input wire logic crc_done_request_out
);
	wire [6:0] cnt = status_out.queue_count;
	wire quiet = clk_en_in && !cmd_wr_in && !cmd_rd_in && !queue_clear_in && !host_rd_in;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	sequence s_push;
		host_wr_in && quiet && cnt < 7'(DEPTH);
	endsequence
	sequence s_full_push;
		host_wr_in && quiet && cnt == 7'(DEPTH);
	endsequence
	property p_push;
		s_push |=> cnt == $past(cnt) + 7'h01;
	endproperty
	a_push: assert property (p_push) else $error("Count did not step on write.");
	property p_full;
		s_full_push |=> status_out.overflow_error && cnt == 7'(DEPTH);
	endproperty
	a_full: assert property (p_full) else $error("Full write not refused.");
	property p_sticky;
		status_out.overflow_error && !queue_clear_in |=> status_out.overflow_error;
	endproperty
	a_sticky: assert property (p_sticky) else $error("Overflow dropped.");
	property p_clear;
		queue_clear_in && !host_wr_in && !cmd_wr_in |=> cnt == 7'h00 && !status_out.overflow_error;
	endproperty
	a_clear: assert property (p_clear) else $error("Clear failed.");
	property p_ne;
		$stable(threshold_in) |-> status_out.near_empty_flag == (cnt <= 7'(threshold_in));
	endproperty
	a_ne: assert property (p_ne) else $error("Near-empty wrong.");
	property p_nf;
		$stable(threshold_in) |-> status_out.near_full_flag == (7'(DEPTH) - cnt <= 7'(threshold_in));
	endproperty
	a_nf: assert property (p_nf) else $error("Near-full wrong.");
	property p_pend;
		$rose(status_out.near_empty_flag) && $past(near_empty_irq_enable_in) |-> pending_out;
	endproperty
	a_pend: assert property (p_pend) else $error("Pending not set.");
	property p_irq;
		irq_out |-> pending_out && $past(irq_activate_in);
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt not gated.");
	property p_crc;
		$rose(crc_done_flag_out) |-> crc_done_request_out && cnt == 7'h00;
	endproperty
	a_crc: assert property (p_crc) else $error("CRC done early.");
endmodule : sfc_queue_crc_assertions
bind sfc_queue_crc sfc_queue_crc_assertions #(.DEPTH(DEPTH)) sfc_chk (.*);

// ==== sfc_host_model.sv ====
/* Host model that writes and reads single bytes on the data port.
   Assumes the bench calls its tasks and owns clock and reset. */
`timescale 1ns/1ps
module sfc_host_model
(
	// Clock.
	input wire logic clk_in,
	// Data port.
	output logic host_wr_out = 1'b0,
	output logic [7:0] host_wdata_out = 8'h00,
	output logic host_rd_out = 1'b0
);
	// Requests come only while no command uses the queue.
	task automatic wr(input logic [7:0] b);
		@(posedge clk_in);
		host_wr_out <= 1'b1;
		host_wdata_out <= b;
		@(posedge clk_in);
		host_wr_out <= 1'b0;
		host_wdata_out <= ~b;
	endtask : wr
	task automatic rd();
		@(posedge clk_in);
		host_rd_out <= 1'b1;
		@(posedge clk_in);
		host_rd_out <= 1'b0;
	endtask : rd
endmodule : sfc_host_model

// ==== sfc_queue_crc_tb_top.sv ====
/* Self-checking bench for the shared queue with CRC engine.
   Assumes a 25 MHz clock; the command port is driven only while the host port is idle. */
`timescale 1ns/1ps
module sfc_queue_crc_tb_top;
	logic clk_in = 1'b0, nrst_in = 1'b0, clk_en_in = 1'b1, cmd_wr_in = 1'b0, cmd_rd_in = 1'b0;
	logic queue_clear_in = 1'b0, pending_clear_in = 1'b0, crc_start_in = 1'b0;
	logic near_empty_irq_enable_in = 1'b1, near_full_irq_enable_in = 1'b1, irq_activate_in = 1'b1;
	logic crc_done_clear_in = 1'b0, host_wr_in, host_rd_in, rd_p = 1'b0;
	logic pending_out, irq_out, crc_done_flag_out, crc_done_request_out;
	logic [7:0] cmd_wdata_in = 8'h00, host_wdata_in, host_rdata_out, cmd_rdata_out, b;
	logic [7:0] crc_output_hi_out, crc_output_lo_out;
	logic [5:0] threshold_in = 6'h08;
	logic [15:0] crc;
	logic [15:0] seeds [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
	logic [7:0] exp_q [$];
	sfc_pkg::sfc_crc_cfg_s crc_cfg_in = '0;
	sfc_pkg::sfc_status_s status_out;
	int err_total = 0, samples_checked = 0, i, s;
	sfc_host_model sfc_host_model_inst (.clk_in(clk_in), .host_wr_out(host_wr_in),
		.host_wdata_out(host_wdata_in), .host_rd_out(host_rd_in));
	sfc_queue_crc sfc_queue_crc_inst (.clk_in(clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
		.host_wr_in(host_wr_in), .host_wdata_in(host_wdata_in), .host_rd_in(host_rd_in),
		.host_rdata_out(host_rdata_out), .cmd_wr_in(cmd_wr_in), .cmd_wdata_in(cmd_wdata_in),
		.cmd_rd_in(cmd_rd_in), .cmd_rdata_out(cmd_rdata_out), .queue_clear_in(queue_clear_in),
		.threshold_in(threshold_in), .near_empty_irq_enable_in(near_empty_irq_enable_in),
		.near_full_irq_enable_in(near_full_irq_enable_in), .irq_activate_in(irq_activate_in),
		.pending_clear_in(pending_clear_in), .crc_cfg_in(crc_cfg_in),
		.crc_start_in(crc_start_in), .crc_done_clear_in(crc_done_clear_in),
		.status_out(status_out), .pending_out(pending_out), .irq_out(irq_out),
		.crc_output_hi_out(crc_output_hi_out), .crc_output_lo_out(crc_output_lo_out),
		.crc_done_flag_out(crc_done_flag_out), .crc_done_request_out(crc_done_request_out));
	initial
		forever #20 clk_in = ~clk_in;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic chk_status(input logic [6:0] n, input logic ovf);
		@(negedge clk_in);
		check({6'h00, status_out}, {6'h00, 7'h40 - n <= 7'(threshold_in), n <= 7'(threshold_in), ovf, n});
	endtask : chk_status
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d, input logic msb);
		for (int k = 0; k < 8; k++)
			if (msb)
				c = (c[15] ^ d[7-k]) ? (c << 1) ^ 16'h1021 : c << 1;
			else
				c = (c[0] ^ d[k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
		return c;
	endfunction : crc_byte
	task automatic finish_test();
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	always @(posedge clk_in)
	begin
		if (rd_p === 1'b1 && exp_q.size() > 0)
			check({8'h00, host_rdata_out}, {8'h00, exp_q.pop_front()});
		rd_p <= host_rd_in;
	end
	initial
	begin
		#(40 * 5000);
		err_total++;
		finish_test();
	end
	initial
	begin
		void'($urandom(64603));
		repeat (10) @(posedge clk_in);
		nrst_in <= 1'b1;
		threshold_in <= 6'($urandom());
		for (i = 0; i < 64; i++)
		begin
			b = 8'($urandom());
			exp_q.push_back(b);
			sfc_host_model_inst.wr(b);
		end
		chk_status(7'h40, 1'b0);
		check({pending_out, irq_out}, 16'h3);
		@(posedge clk_in);
		pending_clear_in <= 1'b1;
		irq_activate_in <= 1'b0;
		sfc_host_model_inst.wr(8'h5a);
		pending_clear_in <= 1'b0;
		chk_status(7'h40, 1'b1);
		check({pending_out, irq_out}, 16'h0);
		for (i = 0; i < 64; i++)
			sfc_host_model_inst.rd();
		@(negedge clk_in);
		check({pending_out, irq_out}, 16'h2);
		sfc_host_model_inst.rd();
		chk_status(7'h00, 1'b1);
		sfc_host_model_inst.wr(8'h11);
		queue_clear_in <= 1'b1;
		@(posedge clk_in);
		queue_clear_in <= 1'b0;
		chk_status(7'h00, 1'b0);
		b = 8'($urandom());
		@(posedge clk_in);
		cmd_wr_in <= 1'b1;
		cmd_wdata_in <= b;
		@(posedge clk_in);
		cmd_wr_in <= 1'b0;
		clk_en_in <= 1'b0;
		sfc_host_model_inst.wr(8'h33);
		clk_en_in <= 1'b1;
		chk_status(7'h01, 1'b0);
		@(posedge clk_in);
		cmd_rd_in <= 1'b1;
		@(posedge clk_in);
		cmd_rd_in <= 1'b0;
		@(negedge clk_in);
		check({8'h00, cmd_rdata_out}, {8'h00, b});
		chk_status(7'h00, 1'b0);
		for (s = 0; s < 8; s++)
		begin
			@(posedge clk_in);
			crc_cfg_in <= '{s[2:1], s[0]};
			crc = seeds[s[2:1]];
			for (i = 0; i < 3; i++)
			begin
				b = 8'($urandom());
				crc = crc_byte(crc, b, s[0]);
				sfc_host_model_inst.wr(b);
			end
			crc_start_in <= 1'b1;
			@(posedge clk_in);
			crc_start_in <= 1'b0;
			for (i = 0; i < 100; i++)
			begin
				@(negedge clk_in);
				if (crc_done_flag_out === 1'b1)
					break;
			end
			check({crc_output_hi_out, crc_output_lo_out}, crc);
			check({crc_done_flag_out, crc_done_request_out}, 16'h3);
			@(posedge clk_in);
			crc_done_clear_in <= 1'b1;
			@(posedge clk_in);
			crc_done_clear_in <= 1'b0;
			@(negedge clk_in);
			check(crc_done_request_out, 16'h0);
		end
		finish_test();
	end
endmodule : sfc_queue_crc_tb_top
